// file: hw/brc_reset_ctrl.sv
// Reset sequencer for a processor module on a shared synchronous bus.
//
// Our own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module brc_reset_ctrl
  import brc_pkg::*;
(
  // Clock and house reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Reset sources
  input wire logic reset_input_pin_in,
  input wire logic system_software_reset_in,
  input wire logic reset_pushbutton_in,
  input wire logic trap_in,
  input wire logic traps_enabled_in,
  // Bus drivers
  input wire logic [BUS_CTL_W-1:0] bus_ctl_drive_in,
  output logic [BUS_CTL_W-1:0] bus_ctl_oe_out,
  input wire logic bus_req_drive_in,
  output logic bus_req_oe_out,
  // Processor side
  output logic cpu_reset_out,
  output logic cache_en_out,
  output logic mmu_en_out,
  output logic snoop_en_out,
  output logic boot_mode_out,
  output logic wbuf_flush_out,
  output logic wbuf_drain_out,
  output logic [3:0] irq_level_out,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  // ========================================================================
  // Reset pin synchroniser
  logic pin_meta;
  logic pin_sync;
  logic full_rst;
  brc_state_t state;
  brc_state_t next_state;
  logic [7:0] cnt;
  brc_ctrl_t ctrl;
  brc_stat_t stat;
  logic wd_evt;
  logic lsr_evt;

  function automatic brc_cause_t pick_cause(input logic wd, input logic lsr,
                                            input logic system_software_reset, input logic pb);
    brc_cause_t c;
    c = CAUSE_POWER_ON;
    if (wd)
      c = CAUSE_WATCHDOG;
    else if (lsr)
      c = CAUSE_LOCAL_SW;
    else if (system_software_reset)
      c = CAUSE_SYS_SW;
    else if (pb)
      c = CAUSE_PUSHBUTTON;
    return c;
  endfunction

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      pin_meta <= 1'b1;
      pin_sync <= 1'b1;
    end
    else
    begin
      pin_meta <= reset_input_pin_in;
      pin_sync <= pin_meta; // see RULE17
    end
  end

  // Pushbutton counts as a power-on grade reset
  assign full_rst = srst_in | pin_sync | system_software_reset_in
                    | reset_pushbutton_in; // see RULE12

  // ========================================================================
  // Sequencer
  assign wd_evt = (state == ST_RUN) && trap_in && !traps_enabled_in
                  && !full_rst; // see RULE5
  assign lsr_evt = (state == ST_RUN) && ctrl.local_reset && !wd_evt
                   && !full_rst; // see RULE7

  always_comb
  begin
    next_state = state;
    case (state)
      ST_RESET:
        next_state = ST_HOLD; // see RULE17
      ST_HOLD:
        if (cnt == 8'h01)
          next_state = ST_RUN;
      ST_PROC_RST:
        if (cnt == 8'h01)
          next_state = ST_RUN;
      ST_RUN:
        if (wd_evt || lsr_evt)
          next_state = ST_PROC_RST;
      default:
        next_state = ST_RESET;
    endcase
    if (full_rst)
      next_state = ST_RESET; // see RULE11
  end

  always_ff @(posedge clk_in)
  begin
    state <= next_state;
    if (full_rst)
      cnt <= HOLD_CLKS; // see RULE2
    else if (state == ST_RUN)
      cnt <= PROC_RST_CLKS;
    else if (cnt != 8'h00)
      cnt <= cnt - 8'h01;
  end

  // ========================================================================
  // Bus drivers
  // Gated straight from the pin so going to high impedance needs no clock edge; driving again waits for ST_RUN
  assign bus_ctl_oe_out = bus_ctl_drive_in
    & {BUS_CTL_W{!reset_input_pin_in && state == ST_RUN}}; // see RULE1, see RULE3
  // Request line is point to point and stays under module control
  assign bus_req_oe_out = bus_req_drive_in; // see RULE4

  // ========================================================================
  // Control and status state
  // Caches, tags and translation buffers hold no reset here at all
  always_ff @(posedge clk_in)
  begin
    if (full_rst)
      ctrl <= CTRL_RESET; // see RULE14, see RULE15, see RULE10
    else if (wd_evt || lsr_evt)
    begin
      ctrl.boot_mode <= 1'b1; // see RULE15
      ctrl.local_reset <= 1'b0; // see RULE16
    end
    else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0]
             && wb_adr_i == REG_CTRL_OFS)
      ctrl <= brc_ctrl_t'(wb_dat_i[4:0]);
  end

  always_ff @(posedge clk_in)
  begin
    if (full_rst)
      stat.watchdog <= 1'b0; // see RULE16
    else if (wd_evt)
      stat.watchdog <= 1'b1;
    else if (lsr_evt)
      stat.watchdog <= 1'b0;
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      stat.cause <= CAUSE_POWER_ON;
    else if (full_rst || wd_evt || lsr_evt)
      stat.cause <= pick_cause(wd_evt, lsr_evt, system_software_reset_in,
                               reset_pushbutton_in); // see RULE9
  end

  // Survives every reset but the house one; setting beats a clear
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      stat.pushbutton_seen <= 1'b0;
    else if (reset_pushbutton_in)
      stat.pushbutton_seen <= 1'b1; // see RULE13
    else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0]
             && wb_adr_i == REG_STAT_OFS && wb_dat_i[4])
      stat.pushbutton_seen <= 1'b0;
  end

  // ========================================================================
  // Processor side outputs
  always_ff @(posedge clk_in)
  begin
    cpu_reset_out <= (next_state != ST_RUN); // see RULE5
    cache_en_out <= ctrl.cache_en;
    mmu_en_out <= ctrl.mmu_en;
    boot_mode_out <= ctrl.boot_mode;
    // Local reset keeps snooping off for its whole span
    snoop_en_out <= ctrl.snoop_en && next_state == ST_RUN; // see RULE7
    wbuf_flush_out <= (full_rst && state != ST_RESET) || lsr_evt; // see RULE16
    wbuf_drain_out <= wd_evt; // see RULE16
    irq_level_out <= wd_evt ? IRQ_LEVEL_WD : 4'h0; // see RULE6
  end

  // ========================================================================
  // Wishbone slave, one wait state, unmapped reads zero
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      if (wb_adr_i == REG_CTRL_OFS)
        wb_dat_o <= {27'h0, ctrl};
      else if (wb_adr_i == REG_STAT_OFS)
        wb_dat_o <= {25'h0, state == ST_RUN, 1'b0, stat};
      else
        wb_dat_o <= 32'h0000_0000;
    end
  end

  // ========================================================================
  // Checks
  tristate_on_reset_a: assert property (@(posedge clk_in) // see RULE1
    reset_input_pin_in |-> bus_ctl_oe_out == '0)
    else $error("shared control driven while reset pin high");

  release_tail_quiet_a: assert property (@(posedge clk_in) // see RULE2
    disable iff (srst_in)
    $fell(pin_sync) |-> (bus_ctl_oe_out == '0) [*3])
    else $error("shared control driven in release tail");

  powerup_quiet_a: assert property (@(posedge clk_in) // see RULE3
    state != ST_RUN |-> bus_ctl_oe_out == '0)
    else $error("shared control driven outside run");

  request_free_a: assert property (@(posedge clk_in) // see RULE4
    disable iff (srst_in)
    (state == ST_HOLD && bus_req_drive_in) |-> bus_req_oe_out)
    else $error("request line blocked during reset tail");

  watchdog_irq_a: assert property (@(posedge clk_in) // see RULE6
    disable iff (srst_in)
    wd_evt |=> irq_level_out == IRQ_LEVEL_WD && stat.watchdog
               && cpu_reset_out ##1 irq_level_out == 4'h0)
    else $error("watchdog did not raise level 15 once");

  local_reset_a: assert property (@(posedge clk_in) // see RULE7
    disable iff (srst_in)
    lsr_evt |=> !ctrl.local_reset && cpu_reset_out && !snoop_en_out
                && wbuf_flush_out)
    else $error("local software reset sequence wrong");

  cause_order_a: assert property (@(posedge clk_in) // see RULE9
    disable iff (srst_in)
    (wd_evt && ctrl.local_reset) |=> stat.cause == CAUSE_WATCHDOG)
    else $error("watchdog did not win cause priority");

  full_clears_a: assert property (@(posedge clk_in) // see RULE14
    full_rst |=> !ctrl.cache_en && !ctrl.mmu_en && !ctrl.snoop_en
                 && ctrl.boot_mode && !stat.watchdog)
    else $error("full reset left state enabled");

  watchdog_keeps_a: assert property (@(posedge clk_in) // see RULE14
    disable iff (srst_in)
    wd_evt |=> $stable(ctrl.cache_en) && $stable(ctrl.mmu_en)
               && ctrl.boot_mode && wbuf_drain_out)
    else $error("watchdog changed cache or mmu state");

  pushbutton_mark_a: assert property (@(posedge clk_in) // see RULE13
    disable iff (srst_in)
    reset_pushbutton_in |=> stat.pushbutton_seen
      && stat.cause == ($past(system_software_reset_in) ? CAUSE_SYS_SW
                        : CAUSE_PUSHBUTTON))
    else $error("pushbutton left no status mark");

  sync_exit_a: assert property (@(posedge clk_in) // see RULE17
    disable iff (srst_in)
    (state == ST_RESET && !full_rst) |=> state == ST_HOLD ##2 state == ST_RUN)
    else $error("exit from reset not on the expected edges");

  reset_idle_a: assert property (@(posedge clk_in) // see RULE11
    srst_in |=> !wb_ack_o && state == ST_RESET && cpu_reset_out)
    else $error("house reset left a machine out of its idle state");

  pin_flush_a: assert property (@(posedge clk_in) // see RULE16
    disable iff (srst_in)
    ($rose(pin_sync) && state == ST_RUN) |=> wbuf_flush_out)
    else $error("reset pin did not empty the write buffers");

  drain_once_a: assert property (@(posedge clk_in) // see RULE16
    disable iff (srst_in)
    wd_evt |=> wbuf_drain_out && !wbuf_flush_out ##1 !wbuf_drain_out)
    else $error("watchdog did not drain the write buffers once");

  boot_on_reset_a: assert property (@(posedge clk_in) // see RULE15
    disable iff (srst_in)
    (wd_evt || lsr_evt) |=> ctrl.boot_mode && !ctrl.local_reset)
    else $error("processor reset left boot mode off");

  watchdog_seen_c: cover property (@(posedge clk_in) wd_evt);
  local_reset_c: cover property (@(posedge clk_in) lsr_evt);
  pushbutton_c: cover property (@(posedge clk_in)
    reset_pushbutton_in ##1 !full_rst [*4] ##1 state == ST_RUN);
  full_to_run_c: cover property (@(posedge clk_in)
    $fell(pin_sync) ##[1:8] state == ST_RUN);
  watchdog_over_local_c: cover property (@(posedge clk_in)
    wd_evt && ctrl.local_reset);

endmodule
`default_nettype wire

// file: hw/brc_pkg.sv
// Constants, types and encodings shared by the bus module reset control.
// ==========================================================================
// What the document requires
// RULE1 - Shared bus control drivers go to high impedance at once, with no clock, while the reset pin is asserted.
// RULE2 - The system holds the shared control lines high during reset and for three clocks after the reset pin is released.
// RULE3 - While powering up and in that three-clock tail the module drives no shared control line.
// RULE4 - The point-to-point request line is exempt from that restriction because it is not shared.
// RULE5 - A trap taken while traps are disabled raises a watchdog reset that resets only this processor.
// RULE6 - A watchdog reset sends a broadcast interrupt at level 15.
// RULE7 - A control register bit starts a local software reset meant only for diagnostics.
// RULE8 - Software must not use the local software reset in normal multiprocessor operation, as it suspends snooping.
// RULE9 - The recorded reset cause follows the order watchdog, local software, system software, pushbutton, power-on.
// The code records a coincident full reset over a watchdog or local reset.
// RULE10 - Reset leaves general registers, caches, tags, translation buffers and memory contents alone.
// RULE11 - Every state machine returns to its initial state on reset; no partial system reset exists.
// RULE12 - The pushbutton gives the same reset as power-on while keeping cache and memory contents.
// RULE13 - A pushbutton reset leaves its mark in the status register.
// RULE14 - Power-on, system software and pushbutton resets turn off caches, MMUs and snooping; watchdog leaves them.
// The code keeps the snoop_en bit on a watchdog but holds snoop_en_out low for the whole processor reset span.
// RULE15 - Every reset sets the boot-mode bit to 1; 0 means translation is in use.
// RULE16 - Every reset clears the local reset bit; watchdog bit reads 1 only after a watchdog; buffers flush or drain.
// RULE17 - Release of the reset pin is synchronised so that all internal logic leaves reset on one clock edge.
package brc_pkg;

  // ========================================================================
  // Register map, byte addresses on the 32-bit bus
  localparam logic [31:0] REG_CTRL_OFS = 32'h0000_0000;
  localparam logic [31:0] REG_STAT_OFS = 32'h0000_0004;

  // ========================================================================
  // Widths and counts
  localparam int BUS_CTL_W = 8;
  localparam logic [7:0] HOLD_CLKS = 8'h03;
  localparam logic [7:0] PROC_RST_CLKS = 8'h10;
  localparam logic [3:0] IRQ_LEVEL_WD = 4'hf;

  // ========================================================================
  // Control register, low bits of word 0
  typedef struct packed {
    logic boot_mode;
    logic snoop_en;
    logic mmu_en;
    logic cache_en;
    logic local_reset;
  } brc_ctrl_t;

  localparam brc_ctrl_t CTRL_RESET = '{boot_mode: 1'b1, snoop_en: 1'b0,
    mmu_en: 1'b0, cache_en: 1'b0, local_reset: 1'b0};

  typedef enum logic [2:0] {
    CAUSE_NONE,
    CAUSE_WATCHDOG,
    CAUSE_LOCAL_SW,
    CAUSE_SYS_SW,
    CAUSE_PUSHBUTTON,
    CAUSE_POWER_ON
  } brc_cause_t;

  // Status register, low bits of word 1
  typedef struct packed {
    logic pushbutton_seen;
    brc_cause_t cause;
    logic watchdog;
  } brc_stat_t;

  typedef enum logic [1:0] {
    ST_RESET,
    ST_HOLD,
    ST_PROC_RST,
    ST_RUN
  } brc_state_t;

endpackage

// file: verification/brc_sys_model.sv
// System reset logic model that drives the module's reset pin.
`timescale 1ns/1ps
`default_nettype none
module brc_sys_model
(
  // Clock and request from the bench
  input wire logic clk_in,
  input wire logic pin_req_in,
  // System side
  output logic reset_input_pin_out,
  output logic hold_high_out
);
  logic [1:0] tail = 2'h0;
  // Pin follows the request with no clock involved
  assign reset_input_pin_out = pin_req_in;
  // Shared lines pulled high in reset and three clocks after
  always_ff @(posedge clk_in)
  begin
    if (pin_req_in)
      tail <= 2'h3;
    else if (tail != 2'h0)
      tail <= tail - 2'h1;
  end
  assign hold_high_out = pin_req_in || (tail != 2'h0);
endmodule
`default_nettype wire

// file: verification/tb_bus_module_reset_control.sv
// Self-checking bench for the bus module reset sequencer.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
  error_cnt++; $display("Error %s exp %0h got %0h", nm, ex, got); end end
module tb_bus_module_reset_control;
  import brc_pkg::*;
  logic clk_in = 1'b0, srst_in = 1'b1, pin_req = 1'b0, system_software_reset = 1'b0;
  logic pb = 1'b0, trap = 1'b0, trap_en = 1'b1, req_drv = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, pin, hold;
  logic [31:0] adr = 32'h0, wdat = 32'h0, rdat;
  logic [BUS_CTL_W-1:0] drv = '1, oe;
  logic req_oe, cpu_rst, cache_o, mmu_o, snoop_o, boot_o, flush, drain;
  logic fl_seen = 1'b0, dr_seen = 1'b0;
  logic [3:0] irq;
  int error_cnt = 0, n_checks = 0, cyc_cnt = 0;
  // ========================================================================
  // Instances
  brc_sys_model u_sys (.clk_in(clk_in), .pin_req_in(pin_req),
    .reset_input_pin_out(pin), .hold_high_out(hold));
  brc_reset_ctrl u_dut (.clk_in(clk_in), .srst_in(srst_in),
    .reset_input_pin_in(pin), .system_software_reset_in(system_software_reset),
    .reset_pushbutton_in(pb), .trap_in(trap), .traps_enabled_in(trap_en),
    .bus_ctl_drive_in(drv), .bus_ctl_oe_out(oe), .bus_req_drive_in(req_drv),
    .bus_req_oe_out(req_oe), .cpu_reset_out(cpu_rst),
    .cache_en_out(cache_o), .mmu_en_out(mmu_o), .snoop_en_out(snoop_o),
    .boot_mode_out(boot_o), .wbuf_flush_out(flush),
    .wbuf_drain_out(drain), .irq_level_out(irq), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(4'hf), .wb_dat_o(rdat), .wb_ack_o(ack));
  // ========================================================================
  // Clock, pulse catchers, timeout
  initial forever #50 clk_in = ~clk_in;
  always @(posedge clk_in)
  begin
    if (flush === 1'b1) fl_seen <= 1'b1;
    if (drain === 1'b1) dr_seen <= 1'b1;
    cyc_cnt++;
    if (cyc_cnt == 5000)
    begin
      error_cnt++;
      conclude();
    end
  end
  // Shared lines stay released while the system holds them high
  always @(negedge clk_in)
    if (hold === 1'b1) `CHK("oe_hold", 8'h00, oe)
  // ========================================================================
  // Wishbone master
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int k;
    k = 0;
    @(posedge clk_in);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    do
    begin
      @(posedge clk_in);
      k++;
    end
    while (ack !== 1'b1 && k < 50);
    q = rdat;
    `CHK("wb_ack", 1'b1, ack)
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] ex);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    `CHK("reg_read", ex, q)
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic wait_run();
    int k;
    k = 0;
    while (cpu_rst !== 1'b0 && k < 60)
    begin
      @(posedge clk_in);
      k++;
    end
    `CHK("run", 1'b0, cpu_rst)
    repeat (2) @(posedge clk_in);
  endtask
  // ========================================================================
  // Scenarios
  task automatic t_por();
    rd_chk(REG_CTRL_OFS, 32'h10);
    wait_run();
    `CHK("boot", 1'b1, boot_o)
    `CHK("cache_off", 1'b0, cache_o)
    rd_chk(REG_STAT_OFS, 32'h4a);
    rd_chk(32'h0000_0040, 32'h0);
  endtask
  task automatic t_pin();
    #1 `CHK("oe_run", 8'hff, oe)
    @(posedge clk_in);
    pin_req <= 1'b1; req_drv <= 1'b1;
    #1 `CHK("oe_async", 8'h00, oe)
    `CHK("req_oe", 1'b1, req_oe)
    repeat (3) @(posedge clk_in);
    pin_req <= 1'b0; req_drv <= 1'b0;
    @(posedge clk_in);
    wait_run();
    `CHK("oe_back", 8'hff, oe)
  endtask
  task automatic t_watchdog();
    dr_seen <= 1'b0; fl_seen <= 1'b0;
    // Trap meets the first cycle with the local reset bit set
    wr(REG_CTRL_OFS, 32'h0f);
    trap <= 1'b1; trap_en <= 1'b0;
    @(posedge clk_in);
    trap <= 1'b0; trap_en <= 1'b1;
    #1 `CHK("irq", IRQ_LEVEL_WD, irq)
    `CHK("cpu_rst", 1'b1, cpu_rst)
    @(posedge clk_in);
    #1 `CHK("irq_end", 4'h0, irq)
    wait_run();
    `CHK("drain", 1'b1, dr_seen)
    `CHK("no_flush", 1'b0, fl_seen)
    `CHK("cache_kept", 1'b1, cache_o)
    `CHK("mmu_kept", 1'b1, mmu_o)
    rd_chk(REG_CTRL_OFS, 32'h1e);
    rd_chk(REG_STAT_OFS, 32'h43);
  endtask
  task automatic t_local();
    fl_seen <= 1'b0;
    // Diagnostic use only, never during normal traffic
    wr(REG_CTRL_OFS, 32'h0f);
    repeat (2) @(posedge clk_in);
    `CHK("lsr_rst", 1'b1, cpu_rst)
    `CHK("snoop_held", 1'b0, snoop_o)
    wait_run();
    `CHK("snoop_back", 1'b1, snoop_o)
    `CHK("flush", 1'b1, fl_seen)
    rd_chk(REG_CTRL_OFS, 32'h1e);
    rd_chk(REG_STAT_OFS, 32'h44);
  endtask
  task automatic t_full();
    @(posedge clk_in);
    system_software_reset <= 1'b1; pb <= 1'b1;
    repeat (3) @(posedge clk_in);
    system_software_reset <= 1'b0; pb <= 1'b0;
    wait_run();
    `CHK("mmu_off", 1'b0, mmu_o)
    `CHK("snoop_off", 1'b0, snoop_o)
    rd_chk(REG_CTRL_OFS, 32'h10);
    rd_chk(REG_STAT_OFS, 32'h56);
    wr(REG_CTRL_OFS, 32'h0e);
    @(posedge clk_in);
    pb <= 1'b1;
    repeat (2) @(posedge clk_in);
    pb <= 1'b0;
    wait_run();
    rd_chk(REG_CTRL_OFS, 32'h10);
    rd_chk(REG_STAT_OFS, 32'h58);
    wr(REG_STAT_OFS, 32'h10);
    rd_chk(REG_STAT_OFS, 32'h48);
  endtask
  // ========================================================================
  // Main sequence and verdict
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge clk_in);
    srst_in <= 1'b0;
    t_por();
    t_pin();
    t_watchdog();
    t_local();
    t_full();
    conclude();
  end
endmodule
`default_nettype wire
